// ---- core/spi_mram_pkg.sv ----
// constants, types and the command set of the serial magnetoresistive memory front end
//
// Overview of operation
// - status byte: lock, protect high/low, enable latch
// - bits 6,5,4,0 stored but otherwise unused
// - status byte reads all zero as delivered
// - latch clear refuses writes; lock plus pin-low refuses status
// - protect pair selects none, quarter, half, all
// - protect bits frozen while pin low and locked
// - pin high: protect bits alone decide, writable
// - status read unless asleep or in wake recovery; device never sets bit 0
// - write-enable command sets the latch
// - write-disable clears latch, blocking later writes
// - latch clears at power-up and write-disable
// - status write: one byte, applied if permitted
// - status bits survive power loss, latch does not
// - 24-bit address, only bits 0 to 18 used
// - read shifts bytes MSB first, address advancing
// - sequential address wraps from top to zero
// - write stores each byte immediately, address advancing
// - back-to-back writes need no waiting
// - after sleep only wake is accepted
// - power loss during sleep restarts in standby
// - wake recovery lasts at least 400 microseconds
// - sleep code B9, wake code AB, no arguments

package spi_mram_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int ADDR_W     = 19;          // decoded array address bits
  localparam int MEM_DEPTH  = 524288;      // bytes in the array
  localparam int ADDR_BYTES = 3;           // address bytes after a read/write code

  //////////////////////////////////////////////////////////////////////////////
  // status byte layout
  localparam int         STAT_LOCK_BIT = 7;  // status_lock_flag
  localparam int         BP_HIGH_BIT   = 3;  // block_protect_high
  localparam int         BP_LOW_BIT    = 2;  // block_protect_low
  localparam int         LATCH_BIT     = 1;  // write_enable_latch
  localparam logic [7:0] STATUS_RESET  = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] CMD_READ          = 8'h03;
  localparam logic [7:0] CMD_WRITE         = 8'h02;
  localparam logic [7:0] CMD_SLEEP         = 8'hB9;
  localparam logic [7:0] CMD_WAKE          = 8'hAB;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_PS        = 4000;  // 250 MHz system clock
  localparam int WAKE_RECOVERY_TIME_US = 400;  // wake_recovery_time
  // least time, rounded up to whole cycles
  localparam int WAKE_RECOVERY_CYC =
    (WAKE_RECOVERY_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_CMD     = 3'b000,  // waiting for the command byte
    ST_ADDR    = 3'b001,  // collecting address bytes
    ST_READ    = 3'b010,  // streaming array bytes out
    ST_WRITE   = 3'b011,  // streaming array bytes in
    ST_STAT_RD = 3'b100,  // streaming the status byte out
    ST_STAT_WR = 3'b101,  // waiting for the status data byte
    ST_SHORT   = 3'b110,  // argument-less command, done at select rise
    ST_IGNORE  = 3'b111   // rest of the frame is dropped
  } frame_state_e;

  typedef struct packed {
    logic cs_n;  // chip select, active low
    logic sck;   // serial clock
    logic si;    // serial data in
    logic wp_n;  // write protect, active low
  } pin_in_s;

  typedef struct packed {
    logic              wr;     // write strobe
    logic              rd;     // read strobe
    logic [ADDR_W-1:0] addr;   // byte address
    logic [7:0]        wdata;  // write data
  } mem_req_s;

endpackage

// ---- core/byte_store.sv ----
// byte-wide array store with a registered read port
`timescale 1ns/1ps
`default_nettype none

module byte_store
  import spi_mram_pkg::*;
(
  // clock and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // access request
  input  wire mem_req_s   req,
  // read data
  output logic [7:0]      rdata_q
);

  // array contents are nonvolatile, so no reset touches them
  logic [7:0] mem [MEM_DEPTH];

  //////////////////////////////////////////////////////////////////////////////
  // write port
  always_ff @(posedge clk) begin
    if (ce && req.wr) begin
      mem[req.addr] <= req.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered read port, one cycle latency
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (ce && req.rd) begin
      rdata_q <= mem[req.addr];
    end
  end

endmodule

`default_nettype wire

// ---- core/spi_mram_command_protection.sv ----
// serial memory command decoder, protection logic and status byte
`timescale 1ns/1ps
`default_nettype none

module spi_mram_command_protection
  import spi_mram_pkg::*;
#(
  parameter int WAKE_RECOVERY_CYCLES = WAKE_RECOVERY_CYC  // shorten in simulation
)(
  // clock, reset, enable
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  // serial link pins
  input  wire logic       CS_N,
  input  wire logic       SCK,
  input  wire logic       SI,
  input  wire logic       WP_N,
  output logic            SO,
  output logic            SO_OE,
  // observation
  output logic [7:0]      STATUS_BYTE,
  output logic            ASLEEP,
  output logic            WAKE_BUSY
);

  localparam int WCNT_W = $clog2(WAKE_RECOVERY_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  pin_in_s           meta_q;       // first synchroniser stage
  pin_in_s           sync_q;       // second synchroniser stage
  pin_in_s           prev_q;       // one cycle older, for edges
  logic              sck_rise;     // sampling edge of the link clock
  logic              sck_fall;     // launch edge of the link clock
  logic              cs_fall;      // frame start
  logic              cs_rise;      // frame end
  logic              active;       // select asserted
  logic [2:0]        bit_cnt_q;    // bits of the current byte
  logic [7:0]        shift_q;      // incoming bits
  logic              byte_done;    // eighth sampling edge
  logic [7:0]        rx_byte;      // completed byte
  frame_state_e      state_q;      // frame decoder state
  logic [7:0]        cmd_q;        // command code of this frame
  logic [1:0]        addr_idx_q;   // address bytes taken
  logic [ADDR_W-1:0] addr_q;       // array address counter
  logic [ADDR_W-1:0] addr_full;    // address once the last byte lands
  logic [7:0]        nv_q = STATUS_RESET; // nonvolatile status bits
  logic              latch_q;      // write_enable_latch
  logic [7:0]        stat_data_q;  // pending status write byte
  logic              stat_pend_q;  // status byte received
  logic              sleep_q;      // sleep mode
  logic [WCNT_W-1:0] wake_cnt_q;   // wake recovery countdown
  logic              wake_busy;    // recovery running
  logic [7:0]        status;       // status as seen by the host
  logic              on_boundary;  // frame ended on a byte boundary
  logic              stat_ok;      // status byte may be written
  logic              arr_wr;       // array write this cycle
  logic              arr_rd;       // array prefetch this cycle
  logic              ld_mem_q;     // load tx from array next cycle
  logic [7:0]        mem_rdata;    // array read data
  mem_req_s          mem_req;      // array request
  logic [7:0]        tx_q;         // outgoing bits
  logic              out_phase;    // state shifts data out

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // true when the address falls in the protected region
  function automatic logic addr_protected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    logic p;
    p = 1'b0;
    case (bp)
      2'b00:   p = 1'b0;                          // nothing protected
      2'b01:   p = (a[ADDR_W-1:ADDR_W-2] == 2'b11); // upper quarter
      2'b10:   p = a[ADDR_W-1];                   // upper half
      default: p = 1'b1;                          // whole array
    endcase
    return p;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the second stage and its one-cycle-older copy feed logic, the first stage none
  always_ff @(posedge CLK) begin
    if (RST) begin
      meta_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
      sync_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
      prev_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
    end else if (CE) begin
      meta_q <= '{cs_n: CS_N, sck: SCK, si: SI, wp_n: WP_N};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges found on the synchronised copies; mode 0 and mode 3 alike,
  // since only edges inside an active frame are used
  assign active   = ~sync_q.cs_n;
  assign sck_rise = active & sync_q.sck & ~prev_q.sck;
  assign sck_fall = active & ~sync_q.sck & prev_q.sck;
  assign cs_fall  = prev_q.cs_n & ~sync_q.cs_n;
  assign cs_rise  = ~prev_q.cs_n & sync_q.cs_n;

  //////////////////////////////////////////////////////////////////////////////
  // bit collection on each sampling edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      bit_cnt_q <= 3'd0;
      shift_q   <= 8'h00;
    end else if (CE) begin
      if (cs_fall) begin
        bit_cnt_q <= 3'd0;
      end else if (sck_rise) begin
        shift_q   <= {shift_q[6:0], sync_q.si};
        bit_cnt_q <= bit_cnt_q + 3'd1;
      end
    end
  end

  assign byte_done   = sck_rise && (bit_cnt_q == 3'd7);
  assign rx_byte     = {shift_q[6:0], sync_q.si};
  assign on_boundary = (bit_cnt_q == 3'd0);
  assign addr_full   = {addr_q[ADDR_W-9:0], rx_byte};

  //////////////////////////////////////////////////////////////////////////////
  // frame decoder
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q    <= ST_IGNORE;
      cmd_q      <= 8'h00;
      addr_idx_q <= 2'd0;
      addr_q     <= '0;
    end else if (CE) begin
      if (cs_fall) begin
        // frames during wake recovery are dropped whole
        state_q    <= wake_busy ? ST_IGNORE : ST_CMD;
        addr_idx_q <= 2'd0;
      end else if (byte_done) begin
        case (state_q)
          ST_CMD: begin
            cmd_q <= rx_byte;
            if (sleep_q) begin
              // only the wake code is heard while asleep
              state_q <= (rx_byte == CMD_WAKE) ? ST_SHORT : ST_IGNORE;
            end else begin
              case (rx_byte)
                CMD_READ, CMD_WRITE:                   state_q <= ST_ADDR;
                CMD_STATUS_READ:                       state_q <= ST_STAT_RD;
                CMD_STATUS_WRITE:                      state_q <= ST_STAT_WR;
                CMD_WRITE_ENABLE, CMD_WRITE_DISABLE,
                CMD_SLEEP:                             state_q <= ST_SHORT;
                default:                               state_q <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            // upper address bits shift out of the counter and are lost
            addr_q     <= addr_full;
            addr_idx_q <= addr_idx_q + 2'd1;
            if (addr_idx_q == 2'(ADDR_BYTES - 1)) begin
              state_q <= (cmd_q == CMD_READ) ? ST_READ : ST_WRITE;
            end
          end
          ST_READ, ST_WRITE: begin
            // natural overflow of the counter gives the wrap to zero
            addr_q <= addr_q + 19'd1;
          end
          ST_STAT_WR: state_q <= ST_IGNORE; // one data byte only
          ST_SHORT:   state_q <= ST_IGNORE; // trailing bytes void the command
          ST_STAT_RD: state_q <= ST_STAT_RD;
          default:    state_q <= ST_IGNORE;
        endcase
      end else if (cs_rise) begin
        state_q <= ST_IGNORE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status write capture; applied only when the frame closes cleanly
  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_data_q <= 8'h00;
      stat_pend_q <= 1'b0;
    end else if (CE) begin
      if (cs_fall || cs_rise) begin
        stat_pend_q <= 1'b0;
      end else if (byte_done && state_q == ST_STAT_WR) begin
        stat_data_q <= rx_byte;
        stat_pend_q <= 1'b1;
      end else if (byte_done) begin
        stat_pend_q <= 1'b0; // a second byte aborts the status write
      end
    end
  end

  // refused unless latch set and not hardware locked by pin low
  assign stat_ok = latch_q && !(nv_q[STAT_LOCK_BIT] && !sync_q.wp_n);

  //////////////////////////////////////////////////////////////////////////////
  // nonvolatile status bits: untouched by reset, factory value zero
  always_ff @(posedge CLK) begin
    if (CE && cs_rise && on_boundary && stat_pend_q && stat_ok) begin
      // latch position is not stored here; bits 6,5,4,0 kept as written
      nv_q <= stat_data_q & ~(8'h01 << LATCH_BIT);
    end
  end
  // a refused status write simply leaves nv_q as it was

  //////////////////////////////////////////////////////////////////////////////
  // write enable latch, volatile
  always_ff @(posedge CLK) begin
    if (RST) begin
      latch_q <= 1'b0;
    end else if (CE && cs_rise && on_boundary && state_q == ST_SHORT && !sleep_q) begin
      if (cmd_q == CMD_WRITE_ENABLE) begin
        latch_q <= 1'b1;
      end else if (cmd_q == CMD_WRITE_DISABLE) begin
        latch_q <= 1'b0;
      end
    end
  end

  // host view of the status byte; bit 0 is only ever what was written
  always_comb begin
    status          = nv_q;
    status[LATCH_BIT] = latch_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sleep mode and wake recovery
  always_ff @(posedge CLK) begin
    if (RST) begin
      sleep_q    <= 1'b0;
      wake_cnt_q <= '0;
    end else if (CE) begin
      if (cs_rise && on_boundary && state_q == ST_SHORT) begin
        if (!sleep_q && cmd_q == CMD_SLEEP) begin
          sleep_q <= 1'b1;
        end else if (sleep_q && cmd_q == CMD_WAKE) begin
          sleep_q    <= 1'b0;
          wake_cnt_q <= WCNT_W'(WAKE_RECOVERY_CYCLES);
        end
      end else if (wake_cnt_q != '0) begin
        wake_cnt_q <= wake_cnt_q - WCNT_W'(1);
      end
    end
  end

  assign wake_busy = (wake_cnt_q != '0);

  //////////////////////////////////////////////////////////////////////////////
  // array access: write at the current address, prefetch the next read byte
  // writes complete in the same cycle, so bursts never stall
  assign arr_wr = byte_done && state_q == ST_WRITE && latch_q
                  && !addr_protected(addr_q, nv_q[BP_HIGH_BIT:BP_LOW_BIT]);
  assign arr_rd = byte_done && ((state_q == ST_ADDR && addr_idx_q == 2'(ADDR_BYTES - 1)
                  && cmd_q == CMD_READ) || state_q == ST_READ);

  always_comb begin
    mem_req.wr    = arr_wr;
    mem_req.rd    = arr_rd;
    mem_req.wdata = rx_byte;
    if (state_q == ST_WRITE) begin
      mem_req.addr = addr_q;
    end else if (state_q == ST_ADDR) begin
      mem_req.addr = addr_full;
    end else begin
      mem_req.addr = addr_q + 19'd1;
    end
  end

  byte_store u_store (
    .clk     (CLK),
    .rst     (RST),
    .ce      (CE),
    .req     (mem_req),
    .rdata_q (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // output shifter; bits leave on launch edges, MSB first
  // limitation: the array byte lands one cycle after the sampling edge, so
  // each link clock half period must span at least two system cycles
  assign out_phase = (state_q == ST_READ) || (state_q == ST_STAT_RD);

  always_ff @(posedge CLK) begin
    if (RST) begin
      ld_mem_q <= 1'b0;
    end else if (CE) begin
      ld_mem_q <= arr_rd;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_q <= 8'h00;
      SO   <= 1'b0;
    end else if (CE) begin
      if (cs_fall) begin
        tx_q <= 8'h00;
      end else if (ld_mem_q) begin
        tx_q <= mem_rdata;
      end else if (byte_done && !sleep_q
                   && ((state_q == ST_CMD && rx_byte == CMD_STATUS_READ) || state_q == ST_STAT_RD)) begin
        tx_q <= status; // status repeats every byte
      end else if (sck_fall && out_phase) begin
        SO   <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // output driven from the first launch edge of the data phase until select rises
  always_ff @(posedge CLK) begin
    if (RST) begin
      SO_OE <= 1'b0;
    end else if (CE) begin
      if (!active) begin
        SO_OE <= 1'b0;
      end else if (sck_fall && out_phase) begin
        SO_OE <= 1'b1; // sleep never reaches a data phase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // observation outputs
  assign STATUS_BYTE = status;
  assign ASLEEP      = sleep_q;
  assign WAKE_BUSY   = wake_busy;

endmodule

`default_nettype wire

// ---- sim/spi_mram_command_protection_chk.sv ----
// port assertions for the serial memory command and protection block
`timescale 1ns/1ps
`default_nettype none

module spi_mram_command_protection_chk
  import spi_mram_pkg::*;
#(
  parameter int WAKE_RECOVERY_CYCLES = WAKE_RECOVERY_CYC  // recovery length in clk cycles
)(
  // clock, reset, enable
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CE,
  // serial link pins
  input wire logic       CS_N,
  input wire logic       SCK,
  input wire logic       SI,
  input wire logic       WP_N,
  input wire logic       SO,
  input wire logic       SO_OE,
  // observation
  input wire logic [7:0] STATUS_BYTE,
  input wire logic       ASLEEP,
  input wire logic       WAKE_BUSY
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);

  ////////////////////////////////////////
  // cycles spent in wake recovery, saturating so it never wraps
  int busy_cnt_q;
  always_ff @(posedge CLK) begin
    if (RST || !WAKE_BUSY) begin
      busy_cnt_q <= 0;
    end else if (busy_cnt_q < WAKE_RECOVERY_CYCLES + 8) begin
      busy_cnt_q <= busy_cnt_q + 1;
    end
  end

  ////////////////////////////////////////
  a_reset_quiets_pins:
    assert property (disable iff (1'b0) RST && CE |=> !SO_OE && !ASLEEP && !WAKE_BUSY && !STATUS_BYTE[LATCH_BIT])
    else $error("reset left output, sleep or latch active");
  a_so_idle_deselected:
    assert property (CS_N [*8] |-> !SO_OE)
    else $error("output driven while deselected");
  a_so_needs_select:
    assert property ($rose(SO_OE) |-> !CS_N && !ASLEEP)
    else $error("output enabled outside an awake frame");
  a_sleep_silent:
    assert property (ASLEEP |-> !SO_OE)
    else $error("output enabled while asleep");
  a_status_at_end:
    assert property (!$stable(STATUS_BYTE) |-> CS_N)
    else $error("status byte changed inside a frame");
  a_lock_freeze:
    assert property ((!WP_N && STATUS_BYTE[STAT_LOCK_BIT]) [*8] |=> $stable({STATUS_BYTE[7:2], STATUS_BYTE[0]}))
    else $error("locked status byte changed with pin low");
  a_wake_min_time:
    assert property ($fell(WAKE_BUSY) |-> busy_cnt_q >= WAKE_RECOVERY_CYCLES)
    else $error("wake recovery ended early");
  a_wake_from_sleep:
    assert property ($fell(ASLEEP) |-> ##[0:1] WAKE_BUSY)
    else $error("sleep left without wake recovery");
  a_busy_awake:
    assert property (WAKE_BUSY |-> !ASLEEP)
    else $error("recovery running while asleep");

  // main scenarios reached
  c_wake_done: cover property ($fell(WAKE_BUSY));
  c_read_out: cover property ($rose(SO_OE));
  c_locked: cover property (!WP_N && STATUS_BYTE[STAT_LOCK_BIT]);
endmodule

bind spi_mram_command_protection spi_mram_command_protection_chk #(
  .WAKE_RECOVERY_CYCLES(WAKE_RECOVERY_CYCLES)
) i_spi_mram_command_protection_chk (
  .CLK(CLK), .RST(RST), .CE(CE), .CS_N(CS_N), .SCK(SCK), .SI(SI), .WP_N(WP_N),
  .SO(SO), .SO_OE(SO_OE), .STATUS_BYTE(STATUS_BYTE), .ASLEEP(ASLEEP), .WAKE_BUSY(WAKE_BUSY)
);
`default_nettype wire

// ---- sim/spi_host_model.sv ----
// host side of the serial link: mode 0 frames, clock unrelated to the system clock
`timescale 1ns/1ps
`default_nettype none

module spi_host_model #(
  parameter real HALF = 62.5  // half of the 125 ns link period
)(
  // link pins driven by the host
  output var logic cs_n,
  output var logic sck,
  output var logic si,
  // serial output as seen on the wire
  input  wire logic so
);
  ////////////////////////////////////////
  // idle: deselected, clock standing low between frames
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // open a frame, clock still standing
  task automatic start_frame();
    cs_n = 1'b0;
    #(HALF);
  endtask

  // one byte each way, msb first, whole bytes only
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #(HALF);
      sck = 1'b1;
      rx[i] = so;
      #(HALF);
      sck = 1'b0;
    end
  endtask

  // close on a byte boundary; select then stays high past its minimum
  task automatic end_frame();
    #(HALF);
    cs_n = 1'b1;
    si = ~si;  // a released line must not keep its last value
    #100;
  endtask
endmodule
`default_nettype wire

// ---- sim/spi_mram_command_protection_test.sv ----
// self-checking bench: command frames against a model of status byte and array
`timescale 1ns/1ps
`default_nettype none

module spi_mram_command_protection_test;
  import spi_mram_pkg::*;

  localparam int WAKE_CYC = 60;     // shortened wake recovery
  localparam int LIMIT    = 80000;  // run ceiling in clk cycles

  logic        clk = 1'b0;          // 250 MHz system clock
  logic        rst = 1'b1;          // power-up reset
  logic        wp_n = 1'b1;         // protect pin
  logic        cs_n, sck, si;       // host link pins
  logic        so, so_oe, asleep, wake_busy;
  logic [7:0]  status;              // observed status byte
  wire logic   so_line = so_oe ? so : 1'bz;  // released output floats
  logic [7:0]  st_m;                // expected status byte
  logic [7:0]  mem_m [int];         // expected array bytes
  logic        sleep_m;             // expected sleep mode
  logic [7:0]  rx;                  // last byte shifted in
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [23:0] probe [3] = '{24'h060000, 24'h040000, 24'h03FFFF};  // quarter, half, lower edges

  always #2 clk = ~clk;

  spi_mram_command_protection #(.WAKE_RECOVERY_CYCLES(WAKE_CYC)) i_spi_mram_command_protection (
    .CLK(clk), .RST(rst), .CE(1'b1), .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
    .SO(so), .SO_OE(so_oe), .STATUS_BYTE(status), .ASLEEP(asleep), .WAKE_BUSY(wake_busy));
  spi_host_model i_spi_host_model (.cs_n(cs_n), .sck(sck), .si(si), .so(so_line));

  ////////////////////////////////////////
  // byte compare; case equality so an unknown bit matches only the same unknown
  task automatic check8(input logic [7:0] exp, input logic [7:0] got, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s expected %h got %h", $time, what, exp, got);
    end
  endtask

  // counts, verdict, stop
  task automatic end_of_test();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, n_mismatch);
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // protect pair decode on the expected status
  function automatic logic prot(input logic [18:0] a);
    case (st_m[BP_HIGH_BIT:BP_LOW_BIT])
      2'b00: return 1'b0;
      2'b01: return a[18:17] == 2'b11;
      2'b10: return a[18];
      default: return 1'b1;
    endcase
  endfunction

  // argument-less command; model tracks latch and sleep
  task automatic cmd(input logic [7:0] c);
    logic woke;
    woke = sleep_m && c == CMD_WAKE;
    i_spi_host_model.start_frame();
    i_spi_host_model.xfer(c, rx);
    i_spi_host_model.end_frame();
    if (!sleep_m || c == CMD_WAKE) begin
      if (c == CMD_WRITE_ENABLE) st_m[LATCH_BIT] = 1'b1;
      if (c == CMD_WRITE_DISABLE) st_m[LATCH_BIT] = 1'b0;
      if (c == CMD_SLEEP) sleep_m = 1'b1;
      if (c == CMD_WAKE) sleep_m = 1'b0;
    end
    check8({7'h0, sleep_m}, {7'h0, asleep}, "sleep mode");
    check8(st_m, status, "status pins");
    if (woke) begin
      check8(8'h01, {7'h0, wake_busy}, "wake recovery");
      for (int i = 0; i < 2 * WAKE_CYC && wake_busy !== 1'b0; i++)
        @(negedge clk);
      check8(8'h00, {7'h0, wake_busy}, "wake end");
    end
  endtask

  // status write, applied when latch and pin allow
  task automatic wstat(input logic [7:0] d);
    i_spi_host_model.start_frame();
    i_spi_host_model.xfer(CMD_STATUS_WRITE, rx);
    i_spi_host_model.xfer(d, rx);
    i_spi_host_model.end_frame();
    if (st_m[LATCH_BIT] && !(st_m[STAT_LOCK_BIT] && !wp_n))
      st_m = {d[7:2], 1'b1, d[0]};
    check8(st_m, status, "status after write");
  endtask

  // status read; the byte repeats, nothing driven while asleep
  task automatic rstat();
    i_spi_host_model.start_frame();
    i_spi_host_model.xfer(CMD_STATUS_READ, rx);
    for (int i = 0; i < 2; i++) begin
      i_spi_host_model.xfer(8'h00, rx);
      check8(sleep_m ? 8'hzz : st_m, rx, "status read");
    end
    i_spi_host_model.end_frame();
  endtask

  // array frame: code, 24-bit address, n bytes at successive addresses
  task automatic acc(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d, input int n);
    logic [18:0] p;
    p = a[18:0];
    i_spi_host_model.start_frame();
    i_spi_host_model.xfer(c, rx);
    for (int i = 2; i >= 0; i--)
      i_spi_host_model.xfer(a[8*i +: 8], rx);
    for (int i = 0; i < n; i++) begin
      i_spi_host_model.xfer(d + 8'(i), rx);
      if (c == CMD_WRITE && st_m[LATCH_BIT] && !prot(p)) mem_m[p] = d + 8'(i);
      if (c == CMD_READ && mem_m.exists(p)) check8(mem_m[p], rx, "array read");
      p = p + 1'b1;
    end
    i_spi_host_model.end_frame();
  endtask

  ////////////////////////////////////////
  initial begin
    st_m = STATUS_RESET;
    sleep_m = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check8(STATUS_RESET, status, "status as delivered");
    // latch gates array writes
    cmd(CMD_WRITE_ENABLE);
    acc(CMD_WRITE, 24'h000010, 8'hA0, 2);
    cmd(CMD_WRITE_DISABLE);
    acc(CMD_WRITE, 24'h000010, 8'h50, 2);
    acc(CMD_READ, 24'h000010, 8'h00, 2);
    done("latch");
    // each protect pair against quarter, half and lower boundaries
    cmd(CMD_WRITE_ENABLE);
    for (int bp = 0; bp < 4; bp++) begin
      wstat({4'h7, 2'(bp), 2'b01});
      rstat();
      foreach (probe[i])
        acc(CMD_WRITE, probe[i], 8'(16 * bp + i), 1);
      foreach (probe[i])
        acc(CMD_READ, probe[i], 8'h00, 1);
    end
    done("block protection");
    // lock flag with pin low freezes the status byte
    wstat(8'h8C);
    @(negedge clk) wp_n = 1'b0;
    wstat(8'h00);
    acc(CMD_WRITE, 24'h03FFFF, 8'h33, 1);
    acc(CMD_READ, 24'h03FFFF, 8'h00, 1);
    @(negedge clk) wp_n = 1'b1;
    wstat(8'h70);
    done("hardware protection");
    // across the top of the array, upper address bits ignored
    acc(CMD_WRITE, 24'hF7FFFE, 8'hC0, 4);
    acc(CMD_READ, 24'h87FFFE, 8'h00, 4);
    done("wraparound");
    // asleep only wake counts
    cmd(CMD_WRITE_DISABLE);
    wstat(8'h0C);
    cmd(CMD_SLEEP);
    cmd(CMD_WRITE_ENABLE);
    rstat();
    cmd(CMD_WAKE);
    rstat();
    done("sleep and wake");
    // power loss while asleep: standby, stored bits kept, latch lost
    cmd(CMD_WRITE_ENABLE);
    cmd(CMD_SLEEP);
    @(negedge clk) rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    st_m[LATCH_BIT] = 1'b0;
    sleep_m = 1'b0;
    check8(8'h00, {7'h0, asleep}, "sleep after reset");
    rstat();
    done("power cycle");
    end_of_test();
  end
endmodule
`default_nettype wire
